// ### bench/axis_command_ack_status_tb.sv
// Bench for the axis acknowledgement bank: bit walk, handshake, base moves.
// Assumes host_model drives the register port; the bench drives commands.
`timescale 1ns/10ps
module axis_command_ack_status_tb;
  import ack_status_pkg::*;
  logic              clock;
  logic              rstn;
  reg_req_t          req;
  logic [WORD_W-1:0] rdata;
  logic [WORD_W-1:0] base_word;
  logic [WORD_W-1:0] v;
  word_pair_t        cmd;
  word_pair_t        accepted;
  word_pair_t        ack;
  word_pair_t        ack_old;
  int                n_mismatch;
  int                comparisons;
  localparam logic [15:0] MAN_IMPL = 16'hedff;
  localparam logic [15:0] DIR_IMPL = 16'h03e7;

  axis_command_ack_status dut_u (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata),
    .cmd(cmd), .accepted(accepted), .ack(ack), .base_word(base_word));
  // Older revision: synchronous feeding flags must stay absent
  axis_command_ack_status #(.UNIT_REVISION(8'h12)) dut_old_u (.clock(clock), .rstn(rstn),
    .req(req), .rdata(), .cmd(cmd), .accepted(accepted), .ack(ack_old), .base_word());
  host_model host_u (.clock(clock), .req(req), .rdata(rdata));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // Ack answers one edge after the inputs are driven
  task automatic step(input word_pair_t c, input word_pair_t a);
    @(posedge clock);
    cmd <= c;
    accepted <= a;
    @(posedge clock);
    #1;
  endtask : step

  task automatic do_reset(input int n);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (n) @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk("base_word", base_word, 16'h0100);
    chk("ack", ack.manual | ack.direct, 16'h0000);
    chk("rdata", rdata, 16'h0000);
    $display("reset test done");
  endtask : do_reset

  task automatic t_walk();
    logic [15:0] m;
    for (int i = 0; i < 16; i++) begin
      m = 16'h0001 << i;
      step({m, m}, {m, m});
      chk("ack.manual", ack.manual, m & MAN_IMPL);
      chk("ack.direct", ack.direct, m & DIR_IMPL);
      chk("old direct", ack_old.direct, m & DIR_IMPL & 16'hfcff);
      chk("old manual", ack_old.manual, m & MAN_IMPL);
    end
    step('1, '1);
    host_u.rd(16'h0100, v);
    chk("rd manual", v, MAN_IMPL);
    host_u.rd(16'h0101, v);
    chk("rd direct", v, DIR_IMPL);
    $display("bit walk test done");
  endtask : t_walk

  task automatic t_hold();
    step('1, '0);
    chk("held", ack.manual, MAN_IMPL);
    step('0, '1);
    chk("dropped", ack.manual | ack.direct, 16'h0000);
    step('1, '0);
    chk("unaccepted", ack.manual | ack.direct, 16'h0000);
    $display("handshake test done");
  endtask : t_hold

  task automatic t_base();
    step('1, '1);
    host_u.wr(16'hfff0, 16'h2000);
    #1;
    chk("base_word", base_word, 16'h2000);
    host_u.rd(16'h2001, v);
    chk("moved direct", v, DIR_IMPL);
    @(posedge clock);
    #1;
    chk("rdata idle", rdata, 16'h0000);
    host_u.rd(16'h0100, v);
    chk("old base", v, 16'h0000);
    host_u.wr(16'h2000, 16'h0000);
    host_u.rd(16'h2000, v);
    chk("ro manual", v, MAN_IMPL);
    host_u.wr(16'hfff0, 16'hffff);
    host_u.rd(16'h0000, v);
    chk("wrapped direct", v, DIR_IMPL);
    step('0, '0);
    $display("base test done");
  endtask : t_base

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    cmd = '0;
    accepted = '0;
    n_mismatch = 0;
    comparisons = 0;
    do_reset(20);
    t_walk();
    t_hold();
    t_base();
    do_reset(2);
    close_out();
  end

  // Whole run needs about 90 cycles
  initial begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    close_out();
  end
endmodule : axis_command_ack_status_tb

// ### bench/host_model.sv
// Host controller model: base writes and word reads on the register port.
// Assumes the bench calls its tasks from one process, off the same clock.
`timescale 1ns/10ps
module host_model (
  input  wire logic                     clock,
  output      ack_status_pkg::reg_req_t req,
  input  wire logic [15:0]              rdata
);
  import ack_status_pkg::*;
  initial req = '0;
  // Released lines show inverted values so no stale address looks valid
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr
  // Read data stands one cycle only, so it is taken right then
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req <= '{addr: ~a, wdata: 16'hffff, wr: 1'b0, rd: 1'b0};
    #1;
    d = rdata;
  endtask : rd
endmodule : host_model

// ### core/ack_status_pkg.sv
// Constants and carriers for the axis command acknowledgement status bank.
// Assumes a single 250 MHz clock and a synchronous host register port.
package ack_status_pkg;

  localparam int ADDR_W = 16;
  localparam int WORD_W = 16;

  // Host register port map
  localparam logic [ADDR_W-1:0] BASE_CFG_ADDR  = 16'hfff0;
  localparam logic [ADDR_W-1:0] BASE_RESET     = 16'h0100;
  localparam logic [ADDR_W-1:0] DIRECT_OFFSET  = 16'h0001;
  localparam logic [WORD_W-1:0] WORD_RESET     = 16'h0000;

  // Unit revision from which the synchronous feeding flags exist
  localparam logic [7:0] SYNC_MIN_REV = 8'h13;

  // Manual operation acknowledgement word, bit masks
  localparam logic [WORD_W-1:0] MAN_SERVO_LOCK  = 16'h0001;
  localparam logic [WORD_W-1:0] MAN_ALARM_RST   = 16'h0002;
  localparam logic [WORD_W-1:0] MAN_DEV_RST     = 16'h0004;
  localparam logic [WORD_W-1:0] MAN_FWD_TORQUE  = 16'h0008;
  localparam logic [WORD_W-1:0] MAN_REV_TORQUE  = 16'h0010;
  localparam logic [WORD_W-1:0] MAN_OVERRIDE    = 16'h0020;
  localparam logic [WORD_W-1:0] MAN_JOG_SPEED   = 16'h0040;
  localparam logic [WORD_W-1:0] MAN_FWD_JOG     = 16'h0080;
  localparam logic [WORD_W-1:0] MAN_REV_JOG     = 16'h0100;
  localparam logic [WORD_W-1:0] MAN_ORG_SEARCH  = 16'h0400;
  localparam logic [WORD_W-1:0] MAN_ORG_RETURN  = 16'h0800;
  localparam logic [WORD_W-1:0] MAN_IMM_STOP    = 16'h2000;
  localparam logic [WORD_W-1:0] MAN_DEC_STOP    = 16'h4000;
  localparam logic [WORD_W-1:0] MAN_SERVO_FREE  = 16'h8000;

  // Direct operation acknowledgement word, bit masks
  localparam logic [WORD_W-1:0] DIR_ABS_MOVE    = 16'h0001;
  localparam logic [WORD_W-1:0] DIR_REL_MOVE    = 16'h0002;
  localparam logic [WORD_W-1:0] DIR_SPEED_CTL   = 16'h0004;
  localparam logic [WORD_W-1:0] DIR_INT_FEED    = 16'h0020;
  localparam logic [WORD_W-1:0] DIR_INT_MASK    = 16'h0040;
  localparam logic [WORD_W-1:0] DIR_PRESET      = 16'h0080;
  localparam logic [WORD_W-1:0] DIR_SYNC_POS    = 16'h0100;
  localparam logic [WORD_W-1:0] DIR_SYNC_VEL    = 16'h0200;

  typedef struct packed {
    logic [WORD_W-1:0] manual;
    logic [WORD_W-1:0] direct;
  } word_pair_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage : ack_status_pkg

// ### core/axis_command_ack_status.sv
// Axis 1 command acknowledgement status words with a small host register port.
// Assumes command and acceptance words are synchronous to clock, and that the
// motion engine raises an acceptance bit only while it honours that command.
//
// Summary of operation
// - Manual ack word sits at configurable base, direct ack word at base plus one.
// - Manual bit 0 acknowledges an accepted servo lock command.
// - Manual bit 1 acknowledges an accepted drive alarm reset command.
// - Manual bit 2 acknowledges an accepted deviation counter reset command.
// - Manual bits 3 and 4 acknowledge forward and reverse torque limit.
// - Manual bit 5 acknowledges an accepted override enable command.
// - Manual bit 6 acknowledges the jogging and inching speed selection.
// - Manual bit 7 acknowledges forward jogging or inching.
// - Manual bit 8 acknowledges reverse jogging or inching.
// - Manual bit 10 acknowledges an accepted origin search command.
// - Manual bit 11 acknowledges an accepted origin return command.
// - Manual bit 13 acknowledges an accepted immediate stop command.
// - Manual bit 14 acknowledges an accepted deceleration stop command.
// - Manual bit 15 acknowledges an accepted servo unlock command.
// - Direct bit 0 acknowledges an accepted absolute movement command.
// - Direct bit 1 acknowledges an accepted relative movement command.
// - Direct bit 2 acknowledges an accepted speed control command.
// - Direct bit 5 acknowledges an accepted interrupt feeding command.
// - Direct bit 6 acknowledges interrupt input mask and position latch enable.
// - Direct bit 7 acknowledges an accepted present position preset.
// - Direct bits 8 and 9 acknowledge synchronous feeding position and velocity.
// - Synchronous feeding flags exist only from unit revision 1.3 on.

`timescale 1ns/10ps

module axis_command_ack_status #(
  parameter logic [7:0] UNIT_REVISION = 8'h13
) (
  input  wire logic                       clock,
  input  wire logic                       rstn,
  input  wire ack_status_pkg::reg_req_t   req,
  output      logic [ack_status_pkg::WORD_W-1:0] rdata,
  input  wire ack_status_pkg::word_pair_t cmd,
  input  wire ack_status_pkg::word_pair_t accepted,
  output      ack_status_pkg::word_pair_t ack,
  output      logic [ack_status_pkg::ADDR_W-1:0] base_word
);
  import ack_status_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Implemented flag positions

  localparam logic SYNC_OK = (UNIT_REVISION >= SYNC_MIN_REV);

  localparam logic [WORD_W-1:0] MAN_IMPL =
      MAN_SERVO_LOCK |
      MAN_ALARM_RST  |
      MAN_DEV_RST    |
      MAN_FWD_TORQUE |
      MAN_REV_TORQUE |
      MAN_OVERRIDE   |
      MAN_JOG_SPEED  |
      MAN_FWD_JOG    |
      MAN_REV_JOG    |
      MAN_ORG_SEARCH |
      MAN_ORG_RETURN |
      MAN_IMM_STOP   |
      MAN_DEC_STOP   |
      MAN_SERVO_FREE;

  // Older units carry no synchronous feeding, so those bits stay dead
  localparam logic [WORD_W-1:0] SYNC_BITS = SYNC_OK ? (DIR_SYNC_POS | DIR_SYNC_VEL)
                                                    : WORD_RESET;

  localparam logic [WORD_W-1:0] DIR_IMPL =
      DIR_ABS_MOVE   |
      DIR_REL_MOVE   |
      DIR_SPEED_CTL  |
      DIR_INT_FEED   |
      DIR_INT_MASK   |
      DIR_PRESET     |
      SYNC_BITS;

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [ADDR_W-1:0] base;
    word_pair_t        ack;
    logic [WORD_W-1:0] rdata;
  } state_t;

  state_t            cur;
  state_t            next_cur;
  logic [WORD_W-1:0] next_manual;
  logic [WORD_W-1:0] next_direct;
  logic [ADDR_W-1:0] direct_addr;

  assign direct_addr = ADDR_W'(cur.base + DIRECT_OFFSET);

  //////////////////////////////////////////////////////////////////////////////
  // Per-bit handshake: set on acceptance, held by the command, dropped with it

  for (genvar b = 0; b < WORD_W; b++) begin : g_bit
    // Unimplemented positions are masked off here so they can never latch
    assign next_manual[b] = MAN_IMPL[b] & cmd.manual[b]
                          & (accepted.manual[b] | cur.ack.manual[b]);
    assign next_direct[b] = DIR_IMPL[b] & cmd.direct[b]
                          & (accepted.direct[b] | cur.ack.direct[b]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state and register port

  always_comb begin
    next_cur            = cur;
    next_cur.ack.manual = next_manual;
    next_cur.ack.direct = next_direct;
    if (req.wr && (req.addr == BASE_CFG_ADDR)) begin
      next_cur.base = req.wdata;
    end
    // Read data stand for one cycle only; idle cycles return zero
    next_cur.rdata = WORD_RESET;
    if (req.rd) begin
      // The config word wins if software moves the base on top of it
      if (req.addr == BASE_CFG_ADDR) begin
        next_cur.rdata = cur.base;
      end else if (req.addr == cur.base) begin
        next_cur.rdata = cur.ack.manual;
      end else if (req.addr == direct_addr) begin
        next_cur.rdata = cur.ack.direct;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cur.base       <= BASE_RESET;
      cur.ack.manual <= WORD_RESET;
      cur.ack.direct <= WORD_RESET;
      cur.rdata      <= WORD_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata     = cur.rdata;
  assign ack       = cur.ack;
  assign base_word = cur.base;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking

  default disable iff (!rstn);

  a_unused_zero: assert property (
    ((ack.manual & ~MAN_IMPL) == WORD_RESET) && ((ack.direct & ~DIR_IMPL) == WORD_RESET)
  ) else $error("unused ack bit set");

  a_sync_revision: assert property (
    !SYNC_OK |-> ((ack.direct & (DIR_SYNC_POS | DIR_SYNC_VEL)) == WORD_RESET)
  ) else $error("sync ack on old revision");

  for (genvar b = 0; b < WORD_W; b++) begin : g_chk
    if (MAN_IMPL[b]) begin : g_man
      a_manual_set: assert property (
        cmd.manual[b] && accepted.manual[b] |=> ack.manual[b]
      ) else $error("manual ack not set");

      a_manual_hold: assert property (
        ack.manual[b] && cmd.manual[b] |=> ack.manual[b]
      ) else $error("manual ack dropped early");
    end
    if (DIR_IMPL[b]) begin : g_dir
      a_direct_set: assert property (
        cmd.direct[b] && accepted.direct[b] |=> ack.direct[b]
      ) else $error("direct ack not set");
    end

    a_ack_clear: assert property (
      !cmd.manual[b] && !cmd.direct[b] |=> !ack.manual[b] && !ack.direct[b]
    ) else $error("ack kept after command drop");

    a_no_spurious: assert property (
      !ack.manual[b] && !accepted.manual[b] |=> !ack.manual[b]
    ) else $error("manual ack set without acceptance");
  end

  a_read_manual: assert property (
    req.rd && (req.addr == base_word) && (req.addr != BASE_CFG_ADDR)
    |=> rdata == $past(ack.manual)
  ) else $error("manual word not at base");

  a_read_direct: assert property (
    req.rd && (req.addr == ADDR_W'(base_word + DIRECT_OFFSET))
    && (req.addr != BASE_CFG_ADDR) && (req.addr != base_word)
    |=> rdata == $past(ack.direct)
  ) else $error("direct word not at base plus one");

  a_read_idle: assert property (
    !req.rd |=> rdata == WORD_RESET
  ) else $error("read data outside read cycle");

  a_base_write: assert property (
    req.wr && (req.addr == BASE_CFG_ADDR) |=> base_word == $past(req.wdata)
  ) else $error("base word not updated");

  //////////////////////////////////////////////////////////////////////////////
  // Per-flag checks: each position is named on its own, so a mask moved in
  // the package fails against the flag it breaks, not a bare bit index

  property p_man_set(logic [WORD_W-1:0] m);
    ((cmd.manual & accepted.manual & m) == m) |=> ((ack.manual & m) == m);
  endproperty

  property p_dir_set(logic [WORD_W-1:0] m);
    ((cmd.direct & accepted.direct & m) == m) |=> ((ack.direct & m) == m);
  endproperty

  property p_man_drop(logic [WORD_W-1:0] m);
    ((cmd.manual & m) == WORD_RESET) |=> ((ack.manual & m) == WORD_RESET);
  endproperty

  property p_dir_drop(logic [WORD_W-1:0] m);
    ((cmd.direct & m) == WORD_RESET) |=> ((ack.direct & m) == WORD_RESET);
  endproperty

  a_servo_lock: assert property (
    p_man_set(MAN_SERVO_LOCK)
  ) else $error("servo lock ack missing");

  a_alarm_reset: assert property (
    p_man_set(MAN_ALARM_RST)
  ) else $error("alarm reset ack missing");

  a_dev_reset: assert property (
    p_man_set(MAN_DEV_RST)
  ) else $error("deviation reset ack missing");

  a_fwd_torque: assert property (
    p_man_set(MAN_FWD_TORQUE)
  ) else $error("forward torque ack missing");

  a_rev_torque: assert property (
    p_man_set(MAN_REV_TORQUE)
  ) else $error("reverse torque ack missing");

  a_override_en: assert property (
    p_man_set(MAN_OVERRIDE)
  ) else $error("override ack missing");

  a_jog_speed: assert property (
    p_man_set(MAN_JOG_SPEED)
  ) else $error("jog speed ack missing");

  a_fwd_jog: assert property (
    p_man_set(MAN_FWD_JOG)
  ) else $error("forward jog ack missing");

  a_rev_jog: assert property (
    p_man_set(MAN_REV_JOG)
  ) else $error("reverse jog ack missing");

  a_org_search: assert property (
    p_man_set(MAN_ORG_SEARCH)
  ) else $error("origin search ack missing");

  a_org_return: assert property (
    p_man_set(MAN_ORG_RETURN)
  ) else $error("origin return ack missing");

  a_imm_stop: assert property (
    p_man_set(MAN_IMM_STOP)
  ) else $error("immediate stop ack missing");

  a_dec_stop: assert property (
    p_man_set(MAN_DEC_STOP)
  ) else $error("deceleration stop ack missing");

  a_servo_free: assert property (
    p_man_set(MAN_SERVO_FREE)
  ) else $error("servo unlock ack missing");

  a_abs_move: assert property (
    p_dir_set(DIR_ABS_MOVE)
  ) else $error("absolute move ack missing");

  a_rel_move: assert property (
    p_dir_set(DIR_REL_MOVE)
  ) else $error("relative move ack missing");

  a_speed_ctl: assert property (
    p_dir_set(DIR_SPEED_CTL)
  ) else $error("speed control ack missing");

  a_int_feed: assert property (
    p_dir_set(DIR_INT_FEED)
  ) else $error("interrupt feed ack missing");

  a_int_mask: assert property (
    p_dir_set(DIR_INT_MASK)
  ) else $error("mask and latch ack missing");

  a_pos_preset: assert property (
    p_dir_set(DIR_PRESET)
  ) else $error("position preset ack missing");

  if (SYNC_OK) begin : g_sync
    a_sync_pos: assert property (
      p_dir_set(DIR_SYNC_POS)
    ) else $error("sync position ack missing");

    a_sync_vel: assert property (
      p_dir_set(DIR_SYNC_VEL)
    ) else $error("sync velocity ack missing");
  end

  // Every flag must fall the cycle after its command is withdrawn
  a_servo_lock_drop: assert property (
    p_man_drop(MAN_SERVO_LOCK)
  ) else $error("servo lock ack kept");
  a_alarm_reset_drop: assert property (
    p_man_drop(MAN_ALARM_RST)
  ) else $error("alarm reset ack kept");
  a_dev_reset_drop: assert property (
    p_man_drop(MAN_DEV_RST)
  ) else $error("deviation reset ack kept");
  a_fwd_torque_drop: assert property (
    p_man_drop(MAN_FWD_TORQUE)
  ) else $error("forward torque ack kept");
  a_rev_torque_drop: assert property (
    p_man_drop(MAN_REV_TORQUE)
  ) else $error("reverse torque ack kept");
  a_override_drop: assert property (
    p_man_drop(MAN_OVERRIDE)
  ) else $error("override ack kept");
  a_jog_speed_drop: assert property (
    p_man_drop(MAN_JOG_SPEED)
  ) else $error("jog speed ack kept");
  a_fwd_jog_drop: assert property (
    p_man_drop(MAN_FWD_JOG)
  ) else $error("forward jog ack kept");
  a_rev_jog_drop: assert property (
    p_man_drop(MAN_REV_JOG)
  ) else $error("reverse jog ack kept");
  a_org_search_drop: assert property (
    p_man_drop(MAN_ORG_SEARCH)
  ) else $error("origin search ack kept");
  a_org_return_drop: assert property (
    p_man_drop(MAN_ORG_RETURN)
  ) else $error("origin return ack kept");
  a_imm_stop_drop: assert property (
    p_man_drop(MAN_IMM_STOP)
  ) else $error("immediate stop ack kept");
  a_dec_stop_drop: assert property (
    p_man_drop(MAN_DEC_STOP)
  ) else $error("deceleration stop ack kept");
  a_servo_free_drop: assert property (
    p_man_drop(MAN_SERVO_FREE)
  ) else $error("servo unlock ack kept");
  a_abs_move_drop: assert property (
    p_dir_drop(DIR_ABS_MOVE)
  ) else $error("absolute move ack kept");
  a_rel_move_drop: assert property (
    p_dir_drop(DIR_REL_MOVE)
  ) else $error("relative move ack kept");
  a_speed_ctl_drop: assert property (
    p_dir_drop(DIR_SPEED_CTL)
  ) else $error("speed control ack kept");
  a_int_feed_drop: assert property (
    p_dir_drop(DIR_INT_FEED)
  ) else $error("interrupt feed ack kept");
  a_int_mask_drop: assert property (
    p_dir_drop(DIR_INT_MASK)
  ) else $error("mask and latch ack kept");
  a_pos_preset_drop: assert property (
    p_dir_drop(DIR_PRESET)
  ) else $error("position preset ack kept");
  a_sync_pos_drop: assert property (
    p_dir_drop(DIR_SYNC_POS)
  ) else $error("sync position ack kept");
  a_sync_vel_drop: assert property (
    p_dir_drop(DIR_SYNC_VEL)
  ) else $error("sync velocity ack kept");

  c_manual_ack: cover property (!ack.manual[0] ##1 ack.manual[0] ##[1:8] !ack.manual[0]);
  c_direct_ack: cover property (!ack.direct[0] ##1 ack.direct[0]);
  c_move_base:  cover property (req.wr && (req.addr == BASE_CFG_ADDR) ##1 req.rd);
  c_read_dir:   cover property (req.rd && (req.addr == ADDR_W'(base_word + DIRECT_OFFSET)));

endmodule : axis_command_ack_status
